/* src/fbp_pkg.sv */
package fbp_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam int unsigned PTR_REG_W = 16;
  localparam int unsigned FIELD_W = 4;
  localparam int unsigned NUM_FILTERS = 4;
  localparam int unsigned SEL_W = 2;
  localparam int unsigned FIRST_FILTER = 4;
  localparam logic [7:0] PTR_REG_OFFSET = 8'h00;
  localparam logic [PTR_REG_W-1:0] PTR_REG_RESET = 16'h0000;

  // field positions, low bit of each nibble
  localparam int unsigned FILTER4_LSB = 0;
  localparam int unsigned FILTER5_LSB = 4;
  localparam int unsigned FILTER6_LSB = 8;
  localparam int unsigned FILTER7_LSB = 12;

  // pointer code that sends a hit to the receive FIFO
  localparam logic [FIELD_W-1:0] PTR_FIFO = 4'hF;

  // ==========================================================================
  // bus constants
  // ==========================================================================
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = DATA_W / 8;
  localparam int unsigned WORD_LSB = 2;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned PTR_BYTES = PTR_REG_W / BYTE_W;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // carriers
  // ==========================================================================
  // acceptance event from the filter logic
  typedef struct packed {
    logic valid;
    logic [SEL_W-1:0] filter;
  } hit_t;

  // destination handed to the buffer store logic
  typedef struct packed {
    logic valid;
    logic [SEL_W-1:0] filter;
    logic to_fifo;
    logic [FIELD_W-1:0] buffer;
  } route_t;

endpackage : fbp_pkg

/* src/ptr_select.sv */
`timescale 1ns/100ps

// ============================================================================
// pointer field selector
// ============================================================================
module ptr_select
  import fbp_pkg::*;
(
  input wire logic [PTR_REG_W-1:0] ptr_reg,
  input wire logic [SEL_W-1:0] filter,
  output logic [FIELD_W-1:0] field
);

  logic [FIELD_W-1:0] fields [NUM_FILTERS];

  // one nibble per filter, filter 4 in the low nibble
  for (genvar i = 0; i < NUM_FILTERS; i++) begin : g_field
    assign fields[i] = ptr_reg[i*FIELD_W +: FIELD_W];
  end

  assign field = fields[filter];

endmodule : ptr_select

/* src/filter_buffer_pointer.sv */
// Contract
// - filter 7 destination comes from pointer bits 15..12.
// - filter 6 destination comes from pointer bits 11..8.
// - filters 5 and 4 use bits 7..4 and 3..0.
// - field value all ones routes accepted messages to the receive FIFO.
// - field values 0..14 route to the fixed buffer of that index.
// - all sixteen bits read/write; reset value zero targets buffer zero.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps

module filter_buffer_pointer
  import fbp_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // acceptance events and resulting destinations
  input wire hit_t hit,
  output route_t route,
  // live pointer register for the buffer store logic
  output logic [PTR_REG_W-1:0] filter4to7_buffer_pointer
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  // the word index needs at least one bit above the byte offset
  if (ADDR_W <= WORD_LSB || ADDR_W > 32) begin : g_bad_addr_w
    $error("filter_buffer_pointer: ADDR_W out of range");
  end
  if (NUM_FILTERS * FIELD_W != PTR_REG_W) begin : g_bad_layout
    $error("filter_buffer_pointer: field layout does not fill the register");
  end

  // ==========================================================================
  // write channel state
  // ==========================================================================
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [STRB_W-1:0] w_strb;

  // handshakes seen at this edge
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire b_done = s_axi_bvalid & s_axi_bready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire r_done = s_axi_rvalid & s_axi_rready;

  // write commits once both halves are in and no response is pending
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;

  // address decode ignores the byte offset within the word
  wire [ADDR_W-1:0] ptr_addr = ADDR_W'(PTR_REG_OFFSET);
  wire wr_hit = aw_addr[ADDR_W-1:WORD_LSB] == ptr_addr[ADDR_W-1:WORD_LSB];
  wire rd_hit = s_axi_araddr[ADDR_W-1:WORD_LSB] == ptr_addr[ADDR_W-1:WORD_LSB];
  wire wr_apply = wr_fire & wr_hit;

  // ==========================================================================
  // pointer register next value
  // ==========================================================================
  logic [PTR_REG_W-1:0] next_ptr;

  // byte lanes follow wstrb; lanes above bit 15 have no storage
  for (genvar b = 0; b < PTR_BYTES; b++) begin : g_lane
    assign next_ptr[b*BYTE_W +: BYTE_W] = (wr_apply & w_strb[b]) ?
      w_data[b*BYTE_W +: BYTE_W] : filter4to7_buffer_pointer[b*BYTE_W +: BYTE_W];
  end

  // ==========================================================================
  // write address and data capture
  // ==========================================================================
  // the two channels are taken independently, in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // ready drops on capture and returns only after the response is taken,
  // so one write at a time is in flight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
    end else if (~aw_held & ~s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
    end else if (~w_held & ~s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // ==========================================================================
  // write response
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR; // unmapped writes are dropped
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // pointer register
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter4to7_buffer_pointer <= PTR_REG_RESET;
    end else begin
      filter4to7_buffer_pointer <= next_ptr;
    end
  end

  // ==========================================================================
  // read channel
  // ==========================================================================
  // upper sixteen bits have no storage and read as zero
  wire [DATA_W-1:0] rd_word = rd_hit ? DATA_W'(filter4to7_buffer_pointer) : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
    end else if (~s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // data is captured at the address edge, so it holds steady under stall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // destination lookup
  // ==========================================================================
  logic [FIELD_W-1:0] hit_field;

  // selector maps filter 4 to bits 3..0 up to filter 7 at bits 15..12
  ptr_select u_ptr_select (
    .ptr_reg(filter4to7_buffer_pointer),
    .filter(hit.filter),
    .field(hit_field)
  );

  // all ones means FIFO; any other code is the fixed buffer index itself
  wire hit_to_fifo = hit_field == PTR_FIFO;
  wire [FIELD_W-1:0] hit_buffer = hit_to_fifo ? '0 : hit_field;

  // the register value before any write at this same edge is used, so a
  // write only steers hits accepted after it has landed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      route <= '0;
    end else begin
      route.valid <= hit.valid;
      route.filter <= hit.valid ? hit.filter : route.filter;
      route.to_fifo <= hit.valid ? hit_to_fifo : route.to_fifo;
      route.buffer <= hit.valid ? hit_buffer : route.buffer;
    end
  end

endmodule : filter_buffer_pointer

/* tb/fbp_asserts.sv */
`timescale 1ns/100ps

module fbp_asserts
  import fbp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire hit_t hit,
  input wire route_t route,
  input wire logic [PTR_REG_W-1:0] filter4to7_buffer_pointer
);
  // short aliases keep the property lines readable
  wire logic [15:0] p = filter4to7_buffer_pointer;
  wire logic [4:0] d = {route.to_fifo, route.buffer};

  // expected {to_fifo, buffer} for one pointer nibble
  function automatic logic [4:0] dst(input logic [3:0] f);
    return (f == PTR_FIFO) ? 5'h10 : {1'h0, f};
  endfunction : dst

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ======
  // destination per filter, looked up before the edge
  AST_F4: assert property (hit.valid && hit.filter == 2'h0 |=> d == dst($past(p[3:0])))
    else $error("filter 4 destination wrong");
  AST_F5: assert property (hit.valid && hit.filter == 2'h1 |=> d == dst($past(p[7:4])))
    else $error("filter 5 destination wrong");
  AST_F6: assert property (hit.valid && hit.filter == 2'h2 |=> d == dst($past(p[11:8])))
    else $error("filter 6 destination wrong");
  AST_F7: assert property (hit.valid && hit.filter == 2'h3 |=> d == dst($past(p[15:12])))
    else $error("filter 7 destination wrong");
  AST_FIFO: assert property (route.valid && route.to_fifo |-> route.buffer == 4'h0)
    else $error("fifo route carries a buffer index");
  // ======
  // register and event timing
  AST_RST: assert property ($fell(rst) |-> p == PTR_REG_RESET)
    else $error("pointer not cleared by reset");
  AST_ONE: assert property (route.valid == $past(hit.valid) && (!route.valid || route.filter == $past(hit.filter)))
    else $error("route pulse does not follow hit");
  AST_HOLD: assert property (!$rose(s_axi_bvalid) |-> $stable(p))
    else $error("pointer changed without a write");

  // main scenarios reached
  cover property (route.valid && route.to_fifo);
  cover property (hit.valid [*2]);
  cover property ($rose(s_axi_bvalid));
  // a hit taken at the very edge that commits a write
  cover property (hit.valid ##1 $rose(s_axi_bvalid));
endmodule : fbp_asserts

bind filter_buffer_pointer fbp_asserts chk_u (
  .clk(clk),
  .rst(rst),
  .s_axi_bvalid(s_axi_bvalid),
  .hit(hit),
  .route(route),
  .filter4to7_buffer_pointer(filter4to7_buffer_pointer)
);

/* tb/fbp_filter_model.sv */
`timescale 1ns/100ps

module fbp_filter_model
  import fbp_pkg::*;
(
  input wire logic clk,
  input wire route_t route,
  output hit_t hit
);
  route_t got [4];
  initial hit = '0;

  // one acceptance per edge; keep leaves valid up for a back-to-back hit
  task automatic fire(input logic [1:0] f, input bit keep);
    hit <= '{1'h1, f};
    @(posedge clk);
    if (!keep) hit <= '0;
  endtask : fire

  // the store logic files each destination by filter
  always @(posedge clk) if (route.valid) got[route.filter] <= route;
endmodule : fbp_filter_model

/* tb/filter_buffer_pointer_tb.sv */
`timescale 1ns/100ps

module filter_buffer_pointer_tb;
  import fbp_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] filter4to7_buffer_pointer;
  hit_t hit;
  route_t route;
  int n_fail = 0;
  int tests_run = 0;

  filter_buffer_pointer dut_u (
    .clk(clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .hit(hit),
    .route(route),
    .filter4to7_buffer_pointer(filter4to7_buffer_pointer)
  );
  fbp_filter_model part_u (.clk(clk), .route(route), .hit(hit));

  // 100 MHz
  always #5 clk = ~clk;

  // ======
  // shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic do_reset;
    rst <= 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
  endtask : do_reset

  // address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s, input logic [1:0] er);
    logic ta, tw;
    ta = 0;
    tw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ta && tw)) begin
      @(posedge clk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge clk);
  endtask : axi_rd

  // back-to-back hits on all four filters, then each destination judged
  task automatic hits(input logic [15:0] v);
    logic [3:0] n;
    logic [31:0] e, g;
    for (int f = 0; f < 4; f++) part_u.fire(2'(f), f < 3);
    repeat (2) @(posedge clk);
    for (int f = 0; f < 4; f++) begin
      n = v[4 * f +: 4];
      e = (n == PTR_FIFO) ? 32'h10 : {28'h0, n};
      g = {27'h0, part_u.got[f].to_fifo, part_u.got[f].buffer};
      chk("route", e, g);
    end
  endtask : hits

  // ======
  // scenarios
  task automatic t_reset;
    chk("ptr", 32'h0, {16'h0, filter4to7_buffer_pointer});
    axi_rd(8'h00, 32'h0, RESP_OKAY);
    hits(16'h0000);
    $display("reset test done");
  endtask : t_reset

  // every code 0..15 lands in every field over the sixteen passes
  task automatic t_route;
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {4'(i), 4'(15 - i), 4'(i ^ 5), 4'(i + 7)};
      axi_wr(8'h00, {16'hFFFF, v}, 4'hF, RESP_OKAY);
      chk("ptr", {16'h0, v}, {16'h0, filter4to7_buffer_pointer});
      axi_rd(8'h00, {16'h0, v}, RESP_OKAY);
      hits(v);
    end
    $display("route test done");
  endtask : t_route

  // hits on filter 7 every cycle while a write is in flight; the hit taken
  // at the commit edge is the one just before bvalid is first seen high
  task automatic t_order;
    axi_wr(8'h00, 32'h00003000, 4'hF, RESP_OKAY);
    fork
      axi_wr(8'h00, 32'h0000F000, 4'hF, RESP_OKAY);
      begin
        do part_u.fire(2'h3, 1'h1); while (!s_axi_bvalid);
        chk("route_at_commit", 32'h3, {27'h0, route.to_fifo, route.buffer});
        part_u.fire(2'h3, 1'h0);
      end
    join
    repeat (2) @(posedge clk);
    chk("route_after", 32'h10, {27'h0, part_u.got[3].to_fifo, part_u.got[3].buffer});
    $display("order test done");
  endtask : t_order

  // byte lanes and an unmapped word, which must leave the pointer alone
  task automatic t_regs;
    axi_wr(8'h00, 32'h0000A5C3, 4'h3, RESP_OKAY);
    axi_wr(8'h00, 32'hFFFF7E00, 4'h2, RESP_OKAY);
    axi_wr(8'h04, 32'h00001234, 4'hF, RESP_SLVERR);
    axi_rd(8'h04, 32'h0, RESP_SLVERR);
    axi_rd(8'h00, 32'h00007EC3, RESP_OKAY);
    $display("register test done");
  endtask : t_regs

  initial begin
    do_reset();
    t_reset();
    t_route();
    t_order();
    t_regs();
    do_reset();
    t_reset();
    tally_and_finish();
  end

  // the run needs a few hundred cycles; this bound only catches a hang
  initial begin
    #50us;
    n_fail++;
    tally_and_finish();
  end
endmodule : filter_buffer_pointer_tb
